// >>> hdl/pcs_pkg.sv
package pcs_pkg;

    // Register word indices on the plain register port.
    localparam logic [3:0] PCS_VIDEO_CONTROL_REGISTER_IDX = 4'h0;
    localparam logic [3:0] PCS_SYNTH_DIVIDER_REGISTER_IDX = 4'h1;
    localparam logic [3:0] PCS_SYNTH_STATUS_REGISTER_IDX = 4'h2;

    localparam int PCS_ADDR_W = 4;
    localparam int PCS_DATA_W = 32;

    // Video control register layout: the clock fields occupy the low five bits.
    localparam int PCS_CTRL_FIELD_W = 5;
    localparam int PCS_SRC_LSB = 0;
    localparam int PCS_SRC_W = 2;
    localparam int PCS_PRESCALE_LSB = 2;
    localparam int PCS_PRESCALE_W = 3;
    localparam logic [PCS_CTRL_FIELD_W-1:0] PCS_CTRL_RESET = 5'h00;

    // Synthesiser divider register layout.
    localparam int PCS_DIV_W = 6;
    localparam int PCS_REF_DIV_LSB = 0;
    localparam int PCS_OSC_DIV_LSB = 8;
    localparam logic [PCS_DIV_W-1:0] PCS_REF_DIV_RESET = 6'h02;
    localparam logic [PCS_DIV_W-1:0] PCS_OSC_DIV_RESET = 6'h02;

    // Status register layout.
    localparam int PCS_STAT_PUMP_LSB = 0;
    localparam int PCS_STAT_LOCK_BIT = 2;
    localparam int PCS_STAT_PIXEL_BIT = 3;

    // Pixel clock sources.
    typedef enum logic [1:0] {
        PCS_SRC_OSCILLATOR = 2'b00,
        PCS_SRC_HIGH_FREQ = 2'b01,
        PCS_SRC_REFERENCE = 2'b10,
        PCS_SRC_STOPPED = 2'b11
    } pcs_source_type;

    // Phase comparator correction state.
    typedef enum logic [1:0] {
        PCS_PUMP_OFF = 2'b00,
        PCS_PUMP_UP = 2'b01,
        PCS_PUMP_DOWN = 2'b10,
        PCS_PUMP_MID = 2'b11
    } pcs_pump_type;

    // Timing: system clock rate and the longest correction pulse still counted as locked.
    localparam int PCS_CLK_PERIOD_NS = 10;
    localparam int PCS_LOCK_TOL_NS = 30;
    localparam int PCS_LOCK_TOL_CYCLES = (PCS_LOCK_TOL_NS / PCS_CLK_PERIOD_NS < 1) ? 1 :
                                         PCS_LOCK_TOL_NS / PCS_CLK_PERIOD_NS;
    localparam int PCS_LOCK_GOOD = 8;
    localparam int PCS_CNT_W = 4;

endpackage : pcs_pkg

// >>> hdl/pcs_pixel_clock_synthesiser.sv
// What this block does
// - The pixel clock is taken from one of three sources chosen by a programmed selection field.
// - The chosen source is divided by a programmed prescale factor from 1 to 8.
// - Source selection and prescale factor live in the low five bits of the video control register.
// - The synthesiser compares against the 32 MHz reference arriving on the reference clock input.
// - The inverted oscillator output carries the complement of the oscillator clock input one mclk cycle later; reset holds it high.
// - One divider divides the reference clock by the reference divisor of the synthesiser divider register.
// - A second divider divides the oscillator clock by the oscillator divisor of that register.
// - Both divisors are six-bit programmable values.
// - Both divider outputs feed a phase comparator that drives the phase compare output.
// - In lock the oscillator runs at oscillator divisor over reference divisor times the reference rate.
// - The comparator is a phase-frequency detector reacting to frequency and phase error.
// - The compare output floats normally, drives low to slow the oscillator and high to speed it up.
// - In lock the output floats except for a brief midpoint drive once per divided reference period.
// - A separate high-frequency clock input is one of the selectable pixel clock sources.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pcs_edge_divider
    import pcs_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic restart,
    input wire logic [PCS_DIV_W-1:0] divisor,
    output logic pulse_q
);
    logic [PCS_DIV_W-1:0] count_q;
    logic [PCS_DIV_W-1:0] last;

    // A divisor of zero behaves as one so the loop never stalls.
    always_comb begin
        last = (divisor == '0) ? '0 : divisor - 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || restart) begin
            count_q <= '0;
            pulse_q <= 1'b0;
        end else if (tick) begin
            if (count_q >= last) begin
                count_q <= '0;
                pulse_q <= 1'b1;
            end else begin
                count_q <= count_q + 1'b1;
                pulse_q <= 1'b0;
            end
        end else begin
            pulse_q <= 1'b0;
        end
    end
endmodule : pcs_edge_divider

module pcs_edge_sampler
    import pcs_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pin,
    output logic level_q,
    output logic rise
);
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else begin
            level_q <= pin;
        end
    end

    assign rise = pin && !level_q;
endmodule : pcs_edge_sampler

module pcs_pixel_clock_synthesiser
    import pcs_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [PCS_ADDR_W-1:0] reg_addr,
    input wire logic [PCS_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [PCS_DATA_W-1:0] reg_rdata,
    input wire logic reference_clock_input,
    input wire logic oscillator_clock_in,
    input wire logic high_freq_clock_in,
    output logic oscillator_clock_inverted_out,
    output logic phase_compare_out,
    output logic phase_compare_oe,
    output logic phase_compare_mid,
    output logic pixel_clock_out
);
    logic [PCS_CTRL_FIELD_W-1:0] video_control_q;
    logic [PCS_DIV_W-1:0] ref_div_q;
    logic [PCS_DIV_W-1:0] osc_div_q;
    logic ctrl_restart;
    logic div_restart;
    logic ref_prev_q;
    logic osc_prev_q;
    logic hf_prev_q;
    logic ref_tick;
    logic osc_tick;
    logic hf_tick;
    logic ref_pulse;
    logic osc_pulse;
    pcs_source_type src_sel;
    logic [PCS_PRESCALE_W-1:0] prescale;
    logic src_level;
    logic src_tick;
    logic [PCS_PRESCALE_W-1:0] pre_cnt_q;
    logic [PCS_PRESCALE_W-1:0] pre_cnt_d;
    logic [PCS_PRESCALE_W-1:0] high_span;
    pcs_pump_type pump_q;
    pcs_pump_type pump_d;
    logic [PCS_CNT_W-1:0] run_q;
    logic [PCS_CNT_W-1:0] good_q;
    logic locked;
    logic [PCS_CTRL_FIELD_W-1:0] ctrl_wr_value;

    // Register writes.
    assign ctrl_wr_value = reg_wdata[PCS_CTRL_FIELD_W-1:0];
    // The control restart is only raised when a clock field really changes, so rewriting the same value is harmless.
    assign ctrl_restart = reg_write && (reg_addr == PCS_VIDEO_CONTROL_REGISTER_IDX) &&
                          (ctrl_wr_value != video_control_q);
    assign div_restart = reg_write && (reg_addr == PCS_SYNTH_DIVIDER_REGISTER_IDX);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            video_control_q <= PCS_CTRL_RESET;
        end else if (reg_write && (reg_addr == PCS_VIDEO_CONTROL_REGISTER_IDX)) begin
            video_control_q <= ctrl_wr_value;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_div_q <= PCS_REF_DIV_RESET;
            osc_div_q <= PCS_OSC_DIV_RESET;
        end else if (div_restart) begin
            ref_div_q <= reg_wdata[PCS_REF_DIV_LSB +: PCS_DIV_W];
            osc_div_q <= reg_wdata[PCS_OSC_DIV_LSB +: PCS_DIV_W];
        end
    end

    // Register reads answer in the following cycle; unmapped indices read zero.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= '0;
            unique case (reg_addr)
                PCS_VIDEO_CONTROL_REGISTER_IDX: begin
                    reg_rdata[PCS_CTRL_FIELD_W-1:0] <= video_control_q;
                end
                PCS_SYNTH_DIVIDER_REGISTER_IDX: begin
                    reg_rdata[PCS_REF_DIV_LSB +: PCS_DIV_W] <= ref_div_q;
                    reg_rdata[PCS_OSC_DIV_LSB +: PCS_DIV_W] <= osc_div_q;
                end
                PCS_SYNTH_STATUS_REGISTER_IDX: begin
                    reg_rdata[PCS_STAT_PUMP_LSB +: $bits(pcs_pump_type)] <= pump_q;
                    reg_rdata[PCS_STAT_LOCK_BIT] <= locked;
                    reg_rdata[PCS_STAT_PIXEL_BIT] <= pixel_clock_out;
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // The clock inputs are sampled by mclk; each must stay well below half its rate.
    pcs_edge_sampler u_ref_in (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(reference_clock_input),
        .level_q(ref_prev_q),
        .rise(ref_tick)
    );

    pcs_edge_sampler u_osc_in (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(oscillator_clock_in),
        .level_q(osc_prev_q),
        .rise(osc_tick)
    );

    pcs_edge_sampler u_hf_in (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(high_freq_clock_in),
        .level_q(hf_prev_q),
        .rise(hf_tick)
    );

    // The inverted copy adds one register stage so that the pin comes from a flip-flop.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oscillator_clock_inverted_out <= 1'b1;
        end else begin
            oscillator_clock_inverted_out <= !oscillator_clock_in;
        end
    end

    // Reference divider.
    pcs_edge_divider u_ref_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(ref_tick),
        .restart(div_restart),
        .divisor(ref_div_q),
        .pulse_q(ref_pulse)
    );

    // Oscillator divider.
    pcs_edge_divider u_osc_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(osc_tick),
        .restart(div_restart),
        .divisor(osc_div_q),
        .pulse_q(osc_pulse)
    );

    // Phase-frequency detector: a reference pulse asks for more speed, an oscillator pulse for less,
    // and when both have arrived they cancel through a single midpoint cycle.
    always_comb begin
        pump_d = pump_q;
        unique case (pump_q)
            PCS_PUMP_OFF, PCS_PUMP_MID: begin
                if (ref_pulse && osc_pulse) begin
                    pump_d = PCS_PUMP_MID;
                end else if (ref_pulse) begin
                    pump_d = PCS_PUMP_UP;
                end else if (osc_pulse) begin
                    pump_d = PCS_PUMP_DOWN;
                end else begin
                    pump_d = PCS_PUMP_OFF;
                end
            end
            PCS_PUMP_UP: begin
                if (osc_pulse) begin
                    pump_d = PCS_PUMP_MID;
                end
            end
            PCS_PUMP_DOWN: begin
                if (ref_pulse) begin
                    pump_d = PCS_PUMP_MID;
                end
            end
        endcase
    end

    // Equal pulse rates settle the loop at osc_div/ref_div times the reference.
    always_ff @(posedge mclk) begin
        if (sys_rst || div_restart) begin
            pump_q <= PCS_PUMP_OFF;
            phase_compare_oe <= 1'b0;
            phase_compare_out <= 1'b0;
            phase_compare_mid <= 1'b0;
        end else begin
            pump_q <= pump_d;
            phase_compare_oe <= (pump_d != PCS_PUMP_OFF);
            phase_compare_out <= (pump_d == PCS_PUMP_UP);
            phase_compare_mid <= (pump_d == PCS_PUMP_MID);
        end
    end

    // Lock indicator: enough consecutive comparisons whose correction pulses stayed short.
    always_ff @(posedge mclk) begin
        if (sys_rst || div_restart) begin
            run_q <= '0;
            good_q <= '0;
        end else begin
            if (pump_q == PCS_PUMP_UP || pump_q == PCS_PUMP_DOWN) begin
                if (run_q != '1) begin
                    run_q <= run_q + 1'b1;
                end
                if (run_q >= PCS_CNT_W'(PCS_LOCK_TOL_CYCLES)) begin
                    good_q <= '0;
                end
            end else if (pump_q == PCS_PUMP_MID) begin
                run_q <= '0;
                if (run_q <= PCS_CNT_W'(PCS_LOCK_TOL_CYCLES) && good_q != PCS_CNT_W'(PCS_LOCK_GOOD)) begin
                    good_q <= good_q + 1'b1;
                end
            end else begin
                run_q <= '0;
            end
        end
    end

    assign locked = (good_q == PCS_CNT_W'(PCS_LOCK_GOOD));

    // Pixel clock source selection.
    assign src_sel = pcs_source_type'(video_control_q[PCS_SRC_LSB +: PCS_SRC_W]);
    assign prescale = video_control_q[PCS_PRESCALE_LSB +: PCS_PRESCALE_W];

    always_comb begin
        src_level = 1'b0;
        src_tick = 1'b0;
        unique case (src_sel)
            PCS_SRC_OSCILLATOR: begin
                src_level = osc_prev_q;
                src_tick = osc_tick;
            end
            PCS_SRC_HIGH_FREQ: begin
                src_level = hf_prev_q;
                src_tick = hf_tick;
            end
            PCS_SRC_REFERENCE: begin
                src_level = ref_prev_q;
                src_tick = ref_tick;
            end
            PCS_SRC_STOPPED: begin
                src_level = 1'b0;
                src_tick = 1'b0;
            end
        endcase
    end

    // Prescaler: field value k divides by k+1. For k above zero the output moves only on a source rising edge,
    // but a field change restarts the count and drives the output low at once, which can cut a pulse short.
    // Half of k+1 rounded down is half of k rounded up, which stays inside the field width;
    // forming k+1 first would need a fourth bit, and a factor of eight would wrap to zero.
    always_comb begin
        if (prescale == '0) begin
            high_span = PCS_PRESCALE_W'(1);
        end else begin
            high_span = (prescale >> 1) + PCS_PRESCALE_W'(prescale[0]);
        end
    end

    always_comb begin
        pre_cnt_d = (pre_cnt_q >= prescale) ? '0 : pre_cnt_q + 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || ctrl_restart) begin
            pre_cnt_q <= '0;
            pixel_clock_out <= 1'b0;
        end else if (prescale == '0) begin
            pre_cnt_q <= '0;
            pixel_clock_out <= src_level;
        end else if (src_tick) begin
            pre_cnt_q <= pre_cnt_d;
            pixel_clock_out <= (pre_cnt_d < high_span);
        end
    end

endmodule : pcs_pixel_clock_synthesiser

`default_nettype wire

// >>> tb/pcs_pixel_clock_synthesiser_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_pixel_clock_synthesiser_chk
    import pcs_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [PCS_ADDR_W-1:0] reg_addr,
    input wire logic [PCS_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [PCS_DATA_W-1:0] reg_rdata,
    input wire logic reference_clock_input,
    input wire logic oscillator_clock_in,
    input wire logic high_freq_clock_in,
    input wire logic oscillator_clock_inverted_out,
    input wire logic phase_compare_out,
    input wire logic phase_compare_oe,
    input wire logic phase_compare_mid,
    input wire logic pixel_clock_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [4:0] ctrl_q;
    logic [1:0] settle_q;
    logic src;
    logic ctrl_wr;
    logic [1:0] pump;
    assign ctrl_wr = reg_write && reg_addr == PCS_VIDEO_CONTROL_REGISTER_IDX;
    assign pump = phase_compare_mid ? 2'h3 : !phase_compare_oe ? 2'h0 : phase_compare_out ? 2'h1 : 2'h2;
    always_comb begin
        case (ctrl_q[1:0])
            2'b00: src = oscillator_clock_in;
            2'b01: src = high_freq_clock_in;
            2'b10: src = reference_clock_input;
            default: src = 1'b0;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_q <= PCS_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= reg_wdata[4:0];
        end
    end
    // A reprogrammed prescaler may take a few cycles to restart, so the
    // pass-through check waits until the setting has stood for three edges.
    always_ff @(posedge mclk) begin
        if (sys_rst || ctrl_wr) begin
            settle_q <= 2'h0;
        end else if (settle_q != 2'h3) begin
            settle_q <= settle_q + 2'h1;
        end
    end
    inv_track_a: assert property (!$past(sys_rst) |-> oscillator_clock_inverted_out == !$past(oscillator_clock_in))
        else $error("inverted oscillator output wrong");
    float_quiet_a: assert property (!phase_compare_oe |-> !phase_compare_out && !phase_compare_mid)
        else $error("compare pin value while floating");
    mid_level_a: assert property (phase_compare_mid |-> phase_compare_oe && !phase_compare_out)
        else $error("midpoint drive wrong");
    rd_unmapped_a: assert property ($past(reg_read) && $past(reg_addr) > 4'h2 |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    rd_ctrl_a: assert property ($past(reg_read) && $past(reg_addr) == 4'h0 |-> reg_rdata == {27'h0, $past(ctrl_q)})
        else $error("control readback wrong");
    rd_div_a: assert property ($past(reg_read) && $past(reg_addr) == 4'h1 |-> reg_rdata[31:14] == 18'h0)
        else $error("divider readback too wide");
    rd_status_a: assert property ($past(reg_read) && $past(reg_addr) == 4'h2 |->
        reg_rdata == {28'h0, $past(pixel_clock_out), reg_rdata[2], $past(pump)})
        else $error("status readback wrong");
    pass_thru_a: assert property (settle_q == 2'h3 && ctrl_q[4:2] == 3'h0 |-> pixel_clock_out == $past(src, 2))
        else $error("undivided pixel clock wrong");
    stopped_low_a: assert property (ctrl_q[1:0] == 2'b11 && settle_q[1] |-> !pixel_clock_out)
        else $error("stopped source toggles");
    cover property (pump == 2'h1);
    cover property (pump == 2'h2);
    cover property (pump == 2'h3);
endmodule : pcs_pixel_clock_synthesiser_chk
bind pcs_pixel_clock_synthesiser pcs_pixel_clock_synthesiser_chk u_chk (.*);
`default_nettype wire

// >>> tb/pcs_vco_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_vco_model #(
    parameter int HALF = 4
) (
    input wire logic mclk,
    input wire logic track,
    input wire logic phase_compare_out,
    input wire logic phase_compare_oe,
    input wire logic phase_compare_mid,
    output logic oscillator_clock_in
);
    logic osc_q = 1'b0;
    int cnt = 0;
    int adj = 0;
    assign oscillator_clock_in = osc_q;
    // Only the current half period is bent, so the model pulls phase but not
    // frequency; with track low it ignores the pin, like a sluggish filter.
    always @(posedge mclk) begin
        if (track && phase_compare_oe && !phase_compare_mid) begin
            adj = phase_compare_out ? -1 : 1;
        end
        cnt = cnt + 1;
        if (cnt >= HALF + adj) begin
            osc_q <= ~osc_q;
            cnt = 0;
            adj = 0;
        end
    end
endmodule : pcs_vco_model
`default_nettype wire

// >>> tb/pcs_pixel_clock_synthesiser_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_pixel_clock_synthesiser_tb_top;
    import pcs_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [PCS_ADDR_W-1:0] reg_addr = 4'h0;
    logic [PCS_DATA_W-1:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [PCS_DATA_W-1:0] reg_rdata;
    logic [2:0] phase_q = 3'h0;
    logic reference_clock_input;
    logic high_freq_clock_in;
    logic oscillator_clock_in;
    logic oscillator_clock_inverted_out;
    logic phase_compare_out;
    logic phase_compare_oe;
    logic phase_compare_mid;
    logic pixel_clock_out;
    logic track = 1'b0;
    logic [31:0] v;
    int mismatches = 0;
    int total_checks = 0;
    // Sampled clocks must stay under half the system rate, so both are slow stand-ins.
    assign reference_clock_input = phase_q[2];
    assign high_freq_clock_in = phase_q[1];
    pcs_pixel_clock_synthesiser dut (.*);
    pcs_vco_model #(.HALF(4)) vco (.*);
    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        phase_q <= phase_q + 3'h1;
    end
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (pixel_clock_out === lvl) begin
            @(negedge mclk);
            n++;
            if (n > 300) begin
                mismatches++;
                results();
            end
        end
    endtask : run_len
    task automatic test_regs();
        rd(4'h0, v);
        check(v, 32'h0);
        rd(4'h1, v);
        check(v, 32'h0000_0202);
        wr(4'h1, 32'hFFFF_FFFF);
        rd(4'h1, v);
        check(v, 32'h0000_3F3F);
        wr(4'h0, 32'hFFFF_FFFF);
        rd(4'h0, v);
        check(v, 32'h0000_001F);
        wr(4'h7, 32'hFFFF_FFFF);
        rd(4'h7, v);
        check(v, 32'h0);
    endtask : test_regs
    task automatic test_pixel();
        int per[3] = '{8, 4, 8};
        int hi;
        int lo;
        int eh;
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 8; k++) begin
                wr(4'h0, {27'h0, k[2:0], s[1:0]});
                @(negedge mclk);
                // Skip the runs disturbed by the restart, then align to the start of a high run.
                repeat (3) run_len(pixel_clock_out, hi);
                run_len(1'b1, hi);
                run_len(1'b0, lo);
                run_len(1'b1, hi);
                run_len(1'b0, lo);
                eh = (k == 0) ? per[s] / 2 : ((k + 1) / 2 > 1 ? (k + 1) / 2 : 1) * per[s];
                check(hi, eh);
                check(hi + lo, (k + 1) * per[s]);
            end
        end
        wr(4'h0, 32'h0000_0017);
        hi = 0;
        repeat (66) begin
            @(negedge mclk);
            if (pixel_clock_out !== 1'b0) begin
                hi++;
            end
        end
        check(hi, 0);
    endtask : test_pixel
    task automatic pump_count(input logic [31:0] div, output int up, output int dn);
        wr(4'h1, div);
        up = 0;
        dn = 0;
        repeat (64) @(negedge mclk);
        repeat (256) begin
            @(negedge mclk);
            up += (phase_compare_oe === 1'b1 && phase_compare_mid === 1'b0 && phase_compare_out === 1'b1);
            dn += (phase_compare_oe === 1'b1 && phase_compare_mid === 1'b0 && phase_compare_out === 1'b0);
        end
    endtask : pump_count
    task automatic test_pump();
        int up;
        int dn;
        pump_count(32'h0000_0402, up, dn);
        check(dn, 0);
        check(up > 0, 1);
        pump_count(32'h0000_0102, up, dn);
        check(up, 0);
        check(dn > 0, 1);
    endtask : test_pump
    task automatic test_lock();
        int oe_n;
        int mid_n;
        track = 1'b1;
        wr(4'h1, 32'h0000_0202);
        repeat (800) @(negedge mclk);
        rd(4'h2, v);
        check(v[2], 1'b1);
        oe_n = 0;
        mid_n = 0;
        repeat (160) begin
            @(negedge mclk);
            oe_n += (phase_compare_oe === 1'b1);
            mid_n += (phase_compare_mid === 1'b1);
        end
        check(oe_n <= 40, 1);
        check(mid_n >= 9, 1);
    endtask : test_lock
    task automatic test_reset();
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(4'h0, v);
        check(v, 32'h0);
        rd(4'h1, v);
        check(v, 32'h0000_0202);
        rd(4'h2, v);
        check(v[2], 1'b0);
    endtask : test_reset
    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        test_regs();
        test_pixel();
        test_pump();
        test_lock();
        test_reset();
        results();
    end
endmodule : pcs_pixel_clock_synthesiser_tb_top
`default_nettype wire
